// >>> verilog/srf_rx_dev.sv
// srf_rx_dev: receiver with the six receive status flags and their read-clear.
// assumes cpu read strobes are one-cycle pulses on sys_clk; line idles high.
module srf_rx_dev #(
  parameter int unsigned SAMPLE_DIV = srf_pkg::SAMPLE_DIV
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // serial line
  srf_link_if.dev         link,
  // cpu read strobes
  input  wire logic       rd_status,
  input  wire logic       rd_data,
  input  wire logic       rd_ctrl3,
  // configuration
  input  wire logic       nine_bit_mode,
  input  wire logic       parity_enable,
  input  wire logic       parity_odd,
  input  wire logic       idle_count_after_stop,
  // register contents
  output logic [7:0]      status_one,
  output logic [7:0]      serial_data_reg,
  output logic            rx_ninth_bit
);
  import srf_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} srf_rx_state_t;

  function automatic logic is_sample(input logic start, input logic [3:0] idx);
    if (start) begin
      is_sample = (idx == SMP_S_A) || (idx == SMP_S_B) || (idx >= SMP_S_LO && idx <= SMP_S_HI);
    end else begin
      is_sample = (idx >= SMP_D_LO) && (idx <= SMP_D_HI);
    end
  endfunction

  // ---------------------------------------------------------------
  // line synchroniser and sample-rate divider
  // ---------------------------------------------------------------
  logic          line_s1_q;
  logic          line_s2_q;
  logic [15:0]   div_q;
  wire           tick_en = (div_q == 16'(SAMPLE_DIV - 1));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
      div_q     <= 16'h0000;
    end else begin
      line_s1_q <= link.line;
      line_s2_q <= line_s1_q;
      div_q     <= tick_en ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // bit framing and majority vote
  // ---------------------------------------------------------------
  srf_rx_state_t state_q;
  srf_rx_state_t state_d;
  logic [3:0]    smp_q;
  logic [2:0]    ones_q;
  logic [2:0]    cnt_q;
  logic [3:0]    bit_q;
  logic [8:0]    shift_q;
  logic          par_q;
  logic          noise_acc_q;

  wire        in_start   = (state_q == RX_START);
  wire        bit_end    = tick_en && (smp_q == SMP_LAST);
  wire        smp_take   = tick_en && is_sample(in_start, smp_q) && (state_q != RX_IDLE);
  wire        bit_val    = in_start ? (ones_q >= START_VOTE) : (ones_q >= BIT_VOTE);
  wire        bit_noise  = (ones_q != 3'h0) && (ones_q != cnt_q);
  wire [3:0]  data_bits  = nine_bit_mode ? DATA_BITS_9 : DATA_BITS_8;
  wire [3:0]  char_bits  = nine_bit_mode ? CHAR_BITS_9 : CHAR_BITS_8;
  wire        fall_seen  = tick_en && (state_q == RX_IDLE) && !line_s2_q;
  wire        stop_end   = bit_end && (state_q == RX_STOP);

  always_comb begin
    state_d = state_q;
    case (state_q)
      RX_IDLE: begin
        if (fall_seen) state_d = RX_START;
      end
      RX_START: begin
        if (bit_end) state_d = bit_val ? RX_IDLE : RX_DATA;
      end
      RX_DATA: begin
        if (bit_end && (bit_q == data_bits - 4'h1)) state_d = RX_STOP;
      end
      RX_STOP: begin
        if (bit_end) state_d = RX_IDLE;
      end
      default: state_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= RX_IDLE;
      smp_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      if (fall_seen) begin
        smp_q <= SMP_FIRST;
      end else if (tick_en) begin
        smp_q <= smp_q + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ones_q <= 3'h0;
      cnt_q  <= 3'h0;
    end else if (bit_end || fall_seen) begin
      ones_q <= 3'h0;
      cnt_q  <= 3'h0;
    end else if (smp_take) begin
      ones_q <= ones_q + {2'h0, line_s2_q};
      cnt_q  <= cnt_q + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_q       <= 4'h0;
      shift_q     <= 9'h000;
      par_q       <= 1'b0;
      noise_acc_q <= 1'b0;
    end else if (fall_seen) begin
      bit_q       <= 4'h0;
      par_q       <= 1'b0;
      noise_acc_q <= 1'b0;
    end else if (bit_end) begin
      noise_acc_q <= noise_acc_q | bit_noise;
      if (state_q == RX_DATA) begin
        shift_q[bit_q] <= bit_val;
        par_q          <= par_q ^ bit_val;
        bit_q          <= bit_q + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // idle line counter
  // ---------------------------------------------------------------
  logic [3:0] idle_q;
  logic [3:0] idle_d;
  logic       idle_arm_q;
  wire        idle_room = (idle_q < char_bits);
  wire        idle_bump = bit_end && idle_room && (
                            (state_q == RX_IDLE && line_s2_q) ||
                            (!idle_count_after_stop && bit_val &&
                             (state_q == RX_DATA || state_q == RX_STOP)));
  wire        idle_set  = idle_bump && (idle_q + 4'h1 == char_bits) && idle_arm_q;

  always_comb begin
    idle_d = idle_q;
    if (idle_bump) begin
      idle_d = idle_q + 4'h1;
    end else if (bit_end && state_q != RX_IDLE) begin
      idle_d = 4'h0;
    end else if (fall_seen) begin
      idle_d = 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // status flags and read-sequence clearing
  // ---------------------------------------------------------------
  logic [ST_N-1:0] flags_q;
  logic [ST_N-1:0] arm_q;
  logic            got_data_q;
  logic            got_c3_q;
  logic [7:0]      data_q;
  logic            r8_q;

  wire             nine_done = (rd_data || got_data_q) && (rd_ctrl3 || got_c3_q);
  wire             full_clr  = arm_q[ST_FULL] && (nine_bit_mode ? nine_done : rd_data);
  wire [ST_N-1:0]  clr_v     = {full_clr, (rd_data ? (arm_q[4:0] & ST_NO_FULL[4:0]) : 5'h00)};
  wire             unread    = flags_q[ST_FULL] && !full_clr;
  wire             load      = stop_end && !unread;
  wire [ST_N-1:0]  set_v;

  assign set_v[ST_FULL]  = load;
  assign set_v[ST_IDLE]  = idle_set;
  assign set_v[ST_OR]    = stop_end && unread;
  assign set_v[ST_NOISE] = load && (noise_acc_q || bit_noise);
  assign set_v[ST_FRM]   = load && !bit_val;
  assign set_v[ST_PAR]   = load && parity_enable && (par_q != parity_odd);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q    <= ST_RESET;
      arm_q      <= ST_RESET;
      got_data_q <= 1'b0;
      got_c3_q   <= 1'b0;
      idle_q     <= 4'h0;
      idle_arm_q <= 1'b0;
    end else begin
      // set wins over clear
      flags_q    <= set_v | (flags_q & ~clr_v);
      arm_q      <= rd_status ? flags_q : (arm_q & ~clr_v);
      got_data_q <= !rd_status && !full_clr && (got_data_q || rd_data);
      got_c3_q   <= !rd_status && !full_clr && (got_c3_q || rd_ctrl3);
      idle_q     <= idle_d;
      idle_arm_q <= load || (idle_arm_q && !idle_set);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= 8'h00;
      r8_q   <= 1'b0;
    end else if (load) begin
      data_q <= shift_q[7:0];
      r8_q   <= nine_bit_mode && shift_q[8];
    end
  end

  assign status_one      = {2'h0, flags_q};
  assign serial_data_reg = data_q;
  assign rx_ninth_bit    = r8_q;

endmodule // srf_rx_dev

// >>> verilog/srf_pkg.sv
// srf_pkg: constants shared by both ends of the receive status flag link.
// assumes one 200 MHz clock (sys_clk) and an active-low asynchronous reset.
package srf_pkg;

  // ---------------------------------------------------------------
  // clock and line timing
  // ---------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ      = 200_000_000;
  localparam int unsigned BAUD_RATE       = 115_200;
  localparam int unsigned SAMPLES_PER_BIT = 16;
  localparam int unsigned SAMPLE_DIV      = SYS_CLK_HZ / (BAUD_RATE * SAMPLES_PER_BIT);

  // ---------------------------------------------------------------
  // sample positions inside one bit time (sample ticks 0..15)
  // ---------------------------------------------------------------
  localparam logic [3:0] SMP_LAST   = 4'hF;
  localparam logic [3:0] SMP_FIRST  = 4'h1;
  localparam logic [3:0] SMP_S_A    = 4'h3;
  localparam logic [3:0] SMP_S_B    = 4'h5;
  localparam logic [3:0] SMP_S_LO   = 4'h7;
  localparam logic [3:0] SMP_S_HI   = 4'hB;
  localparam logic [3:0] SMP_D_LO   = 4'h7;
  localparam logic [3:0] SMP_D_HI   = 4'h9;
  localparam logic [2:0] START_VOTE = 3'h4;
  localparam logic [2:0] BIT_VOTE   = 3'h2;

  // ---------------------------------------------------------------
  // character format
  // ---------------------------------------------------------------
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [3:0] CHAR_BITS_8 = 4'hA;
  localparam logic [3:0] CHAR_BITS_9 = 4'hB;
  localparam int unsigned FRAME_W    = 11;
  localparam int unsigned WORD_W     = 9;
  localparam int unsigned FIFO_DEPTH = 4;

  // ---------------------------------------------------------------
  // status_one layout and reset value
  // ---------------------------------------------------------------
  localparam int unsigned ST_PAR   = 0;
  localparam int unsigned ST_FRM   = 1;
  localparam int unsigned ST_NOISE = 2;
  localparam int unsigned ST_OR    = 3;
  localparam int unsigned ST_IDLE  = 4;
  localparam int unsigned ST_FULL  = 5;
  localparam int unsigned ST_N     = 6;
  localparam logic [5:0]  ST_RESET   = 6'h00;
  localparam logic [5:0]  ST_NO_FULL = 6'h1F;

endpackage : srf_pkg

// >>> verilog/srf_link_if.sv
// srf_link_if: the serial receive line between far transmitter and device.
// assumes both ends run on the same sys_clk; the device still synchronises.
interface srf_link_if;
  logic line;

  // ---------------------------------------------------------------
  // one modport for each party
  // ---------------------------------------------------------------
  modport dev (input  line);
  modport far (output line);
endinterface // srf_link_if

// >>> verilog/srf_tx_host.sv
// srf_tx_host: far transmitter with a small word buffer in front of it.
// assumes the user side runs on sys_clk and honours valid/ready.
module srf_fifo #(
  parameter int unsigned WIDTH = srf_pkg::WORD_W,
  parameter int unsigned DEPTH = srf_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  import srf_pkg::*;

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push  = in_valid && in_ready;
  wire              pop   = out_valid && out_ready;
  wire              wr_top = (wr_q == AW'(DEPTH - 1));
  wire              rd_top = (rd_q == AW'(DEPTH - 1));

  assign in_ready  = (cnt_q != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge sys_clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_top ? '0 : wr_q + AW'(1);
      if (pop)  rd_q <= rd_top ? '0 : rd_q + AW'(1);
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

endmodule // srf_fifo

module srf_tx_host #(
  parameter int unsigned SAMPLE_DIV = srf_pkg::SAMPLE_DIV
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // serial line
  srf_link_if.far         link,
  // words to send
  input  wire logic       push_valid,
  output logic            push_ready,
  input  wire logic [8:0] push_data,
  // configuration
  input  wire logic       nine_bit_mode,
  input  wire logic       parity_enable,
  input  wire logic       parity_odd,
  // status
  output logic            tx_busy
);
  import srf_pkg::*;

  typedef enum logic {TX_IDLE, TX_SEND} srf_tx_state_t;

  localparam int unsigned BIT_DIV = SAMPLE_DIV * SAMPLES_PER_BIT;

  // ---------------------------------------------------------------
  // buffer and frame build
  // ---------------------------------------------------------------
  srf_tx_state_t      state_q;
  logic               q_valid;
  logic [8:0]         q_data;
  wire                q_ready = (state_q == TX_IDLE);
  wire                take    = q_valid && q_ready;
  wire                p9      = ^q_data[7:0] ^ parity_odd;
  wire                p8      = ^q_data[6:0] ^ parity_odd;
  wire [8:0]          db9     = {parity_enable ? p9 : q_data[8], q_data[7:0]};
  wire [7:0]          db8     = {parity_enable ? p8 : q_data[7], q_data[6:0]};
  wire [FRAME_W-1:0]  frame_w = nine_bit_mode ? {1'b1, db9, 1'b0} : {2'h3, db8, 1'b0};
  wire [3:0]          nbits   = nine_bit_mode ? CHAR_BITS_9 : CHAR_BITS_8;

  srf_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  // ---------------------------------------------------------------
  // bit timer and shifter
  // ---------------------------------------------------------------
  logic [19:0]        div_q;
  logic [FRAME_W-1:0] frame_q;
  logic [3:0]         left_q;
  logic               line_q;
  wire                bit_en = (div_q == 20'(BIT_DIV - 1));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= TX_IDLE;
      div_q   <= 20'h00000;
      frame_q <= '1;
      left_q  <= 4'h0;
      line_q  <= 1'b1;
    end else if (take) begin
      state_q <= TX_SEND;
      div_q   <= 20'h00000;
      frame_q <= frame_w >> 1;
      left_q  <= nbits - 4'h1;
      line_q  <= frame_w[0];
    end else if (state_q == TX_SEND) begin
      div_q <= bit_en ? 20'h00000 : div_q + 20'h00001;
      if (bit_en) begin
        if (left_q != 4'h0) begin
          line_q  <= frame_q[0]; // stop bit shifted last is high
          frame_q <= frame_q >> 1;
          left_q  <= left_q - 4'h1;
        end else begin
          state_q <= TX_IDLE;
        end
      end
    end
  end

  assign link.line = line_q;
  assign tx_busy   = (state_q == TX_SEND);

endmodule // srf_tx_host

// >>> tb/srf_link_sva.sv
// srf_link_sva: timing of the receive status flags seen beside the first link.
// assumes one sys_clk domain; sees the receiver's read strobes and status byte.
module srf_link_sva (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // serial line
  input wire logic       line,
  // receiver cpu side
  input wire logic       rd_status,
  input wire logic       rd_data,
  input wire logic       rd_ctrl3,
  input wire logic       nine_bit_mode,
  input wire logic [7:0] status_one
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // read-clear sequences
  // ---------------------------------------------------------------
  property p_full_clear8;
    rd_status && status_one[5] && !nine_bit_mode ##1 rd_data && !rd_status |=> !status_one[5];
  endproperty
  a_full_clear8: assert property (p_full_clear8) else $error("full kept after reads");
  property p_full_hold9;
    rd_status && status_one[5] && nine_bit_mode ##1 rd_data && !rd_ctrl3 |=> status_one[5];
  endproperty
  a_full_hold9: assert property (p_full_hold9) else $error("full cleared early");
  // full level seen by the most recent status read
  logic saw_full_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      saw_full_q <= 1'b0;
    end else if (rd_status) begin
      saw_full_q <= status_one[5];
    end
  end
  property p_unarmed;
    rd_data && !rd_status && !saw_full_q && status_one[5] |=> status_one[5];
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed full cleared");
  property p_or_clear;
    rd_status && status_one[3] ##1 rd_data && !rd_status |=> !status_one[3];
  endproperty
  a_or_clear: assert property (p_or_clear) else $error("overrun kept after reads");
  property p_idle_clear;
    rd_status && status_one[4] ##1 rd_data && !rd_status |=> !status_one[4];
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle kept after reads");
  property p_pf_clear;
    rd_status && status_one[0] ##1 rd_data && !rd_status |=> !status_one[0];
  endproperty
  a_pf_clear: assert property (p_pf_clear) else $error("parity kept after reads");
  // ---------------------------------------------------------------
  // setting conditions
  // ---------------------------------------------------------------
  property p_or_set;
    $rose(status_one[3]) |-> $past(status_one[5]) && status_one[5];
  endproperty
  a_or_set: assert property (p_or_set) else $error("overrun without full");
  property p_pf_full;
    $rose(status_one[0]) |-> status_one[5];
  endproperty
  a_pf_full: assert property (p_pf_full) else $error("parity without full");
  property p_idle_line;
    $rose(status_one[4]) |-> $past(line, 1) && $past(line, 8);
  endproperty
  a_idle_line: assert property (p_idle_line) else $error("idle on busy line");
endmodule // srf_link_sva

// >>> tb/sci_receive_status_flags_bench.sv
// sci_receive_status_flags_bench: host sends words to the receiver, bench judges flags.
// assumes SAMPLE_DIV of 2; a second receiver takes frames the bench spoils on purpose.
module sci_receive_status_flags_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import srf_pkg::*;
  localparam int SD = 2;
  localparam int BT = 16 * SD;
  logic       sys_clk, rst_b, rd_status, rd_data, rd_ctrl3;
  logic       nine_bit_mode, parity_enable, parity_odd, host_odd, idle_count_after_stop;
  logic       push_valid, push_ready, tx_busy, rx_ninth_bit, line_two;
  logic [8:0] push_data;
  logic [7:0] status_one, serial_data_reg, status_two, data_two;
  int         err_count, cmp_count;
  srf_link_if srf_link_if_i ();
  srf_link_if srf_link_if_fault_i ();
  assign srf_link_if_fault_i.line = line_two;
  srf_tx_host #(.SAMPLE_DIV(SD)) srf_tx_host_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(srf_link_if_i.far), .push_valid(push_valid),
    .push_ready(push_ready), .push_data(push_data), .nine_bit_mode(nine_bit_mode),
    .parity_enable(parity_enable), .parity_odd(host_odd), .tx_busy(tx_busy));
  srf_rx_dev #(.SAMPLE_DIV(SD)) srf_rx_dev_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(srf_link_if_i.dev), .rd_status(rd_status),
    .rd_data(rd_data), .rd_ctrl3(rd_ctrl3), .nine_bit_mode(nine_bit_mode),
    .parity_enable(parity_enable), .parity_odd(parity_odd),
    .idle_count_after_stop(idle_count_after_stop), .status_one(status_one),
    .serial_data_reg(serial_data_reg), .rx_ninth_bit(rx_ninth_bit));
  srf_rx_dev #(.SAMPLE_DIV(SD)) srf_rx_dev_fault_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(srf_link_if_fault_i.dev), .rd_status(rd_status),
    .rd_data(rd_data), .rd_ctrl3(rd_ctrl3), .nine_bit_mode(nine_bit_mode),
    .parity_enable(parity_enable), .parity_odd(parity_odd),
    .idle_count_after_stop(idle_count_after_stop), .status_one(status_two),
    .serial_data_reg(data_two), .rx_ninth_bit());
  srf_link_sva srf_link_sva_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .line(srf_link_if_i.line), .rd_status(rd_status),
    .rd_data(rd_data), .rd_ctrl3(rd_ctrl3), .nine_bit_mode(nine_bit_mode),
    .status_one(status_one));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic timed_out(input int n, input int lim);
    if (n >= lim) begin
      err_count++;
      summarize();
    end
  endtask
  task automatic wait_flag(input bit two, input int b, input int lim);
    int n;
    for (n = 0; n < lim && (two ? status_two[b] : status_one[b]) !== 1'b1; n++) tick(1);
    timed_out(n, lim);
  endtask
  task automatic send(input logic [8:0] w);
    int n;
    for (n = 0; n < 4 * BT && push_ready !== 1'b1; n++) tick(1);
    timed_out(n, 4 * BT);
    push_data = w;
    push_valid = 1'b1;
    tick(1);
    push_valid = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic s, input logic d, input logic c);
    {rd_status, rd_data, rd_ctrl3} = {s, d, c};
    tick(1);
    {rd_status, rd_data, rd_ctrl3} = 3'h0;
    tick(1);
  endtask
  // status read, data read on the very next edge
  task automatic rd_pair();
    rd_status = 1'b1;
    tick(1);
    {rd_status, rd_data} = 2'h1;
    tick(1);
    rd_data = 1'b0;
    tick(1);
  endtask
  task automatic settle(input bit two);
    wait_flag(two, ST_IDLE, 14 * BT);
    rd_pair();
    chk("status", two ? status_two : status_one, 8'h00);
  endtask
  // spoiled frame on the second line: stop level and one flipped data sample
  task automatic frame_two(input logic [7:0] d, input logic stop, input logic glitch);
    logic [9:0] bits;
    int         i;
    bits = {stop, d, 1'b0};
    for (i = 0; i < 10; i++) begin
      line_two = bits[i];
      tick(8 * SD);
      line_two = bits[i] ^ (glitch && i == 1);
      tick(SD);
      line_two = bits[i];
      tick(7 * SD);
    end
    line_two = 1'b1;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_idle_count(input logic opt);
    idle_count_after_stop = opt;
    send(9'h0FF);
    chk("busy", {7'h00, tx_busy}, 8'h01);
    wait_flag(0, ST_FULL, 12 * BT);
    chk("data", serial_data_reg, 8'hFF);
    if (opt) begin
      tick(8 * BT);
      chk("status", status_one, 8'h20);
    end
    wait_flag(0, ST_IDLE, opt ? 4 * BT : 2 * BT);
    chk("status", status_one, 8'h30);
    chk("busy", {7'h00, tx_busy}, 8'h00);
    rd_pair();
    chk("status", status_one, 8'h00);
    tick(12 * BT);
    chk("status", status_one, 8'h00);
  endtask
  task automatic s_unarmed();
    send(9'h03C);
    rd(1'b1, 1'b0, 1'b0);
    wait_flag(0, ST_FULL, 12 * BT);
    rd(1'b0, 1'b1, 1'b0);
    chk("status", status_one, 8'h20);
    settle(0);
  endtask
  task automatic s_fifo_overrun();
    int i;
    for (i = 0; i < 5; i++) send(9'(8'h30 + i));
    chk("ready", {7'h00, push_ready}, 8'h00);
    for (i = 0; i < 5; i++) begin
      wait_flag(0, ST_FULL, 12 * BT);
      chk("data", serial_data_reg, 8'(8'h30 + i));
      rd_pair();
    end
    send(9'h011);
    send(9'h022);
    wait_flag(0, ST_OR, 24 * BT);
    chk("status", status_one, 8'h28);
    chk("data", serial_data_reg, 8'h11);
    rd_pair();
    chk("status", status_one, 8'h00);
    settle(0);
  endtask
  task automatic s_nine();
    nine_bit_mode = 1'b1;
    send(9'h1A5);
    wait_flag(0, ST_FULL, 13 * BT);
    chk("ninth", {serial_data_reg[0], rx_ninth_bit, 6'h00}, 8'hC0);
    rd_pair();
    chk("status", status_one, 8'h20);
    rd(1'b0, 1'b0, 1'b1);
    chk("status", status_one, 8'h00);
    send(9'h05A);
    wait_flag(0, ST_FULL, 13 * BT);
    rd(1'b1, 1'b0, 1'b0);
    rd(1'b0, 1'b0, 1'b1);
    chk("status", status_one, 8'h20);
    rd(1'b0, 1'b1, 1'b0);
    chk("status", status_one, 8'h00);
    settle(0);
    nine_bit_mode = 1'b0;
  endtask
  task automatic s_parity();
    parity_enable = 1'b1;
    parity_odd = 1'b1;
    send(9'h055);
    wait_flag(0, ST_FULL, 12 * BT);
    chk("status", status_one, 8'h21);
    rd_pair();
    chk("status", status_one, 8'h00);
    settle(0);
    host_odd = 1'b1;
    send(9'h055);
    wait_flag(0, ST_FULL, 12 * BT);
    chk("status", status_one, 8'h20);
    settle(0);
    parity_enable = 1'b0;
  endtask
  task automatic s_line_faults();
    frame_two(8'h00, 1'b1, 1'b1);
    wait_flag(1, ST_FULL, 2 * BT);
    chk("status two", status_two, 8'h24);
    chk("data two", data_two, 8'h00);
    rd_pair();
    chk("status two", status_two, 8'h00);
    settle(1);
    frame_two(8'h5A, 1'b0, 1'b0);
    wait_flag(1, ST_FULL, 2 * BT);
    chk("status two", status_two, 8'h22);
    rd_pair();
    chk("status two", status_two, 8'h00);
    settle(1);
  endtask
  task automatic summarize();
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_b, rd_status, rd_data, rd_ctrl3, push_valid, line_two} = 6'h01;
    {nine_bit_mode, parity_enable, parity_odd, host_odd, idle_count_after_stop} = 5'h00;
    push_data = 9'h000;
    err_count = 0;
    cmp_count = 0;
    tick(16);
    rst_b = 1'b1;
    chk("status", status_one, 8'h00);
    s_idle_count(1'b0);
    s_idle_count(1'b1);
    s_unarmed();
    s_fifo_overrun();
    s_nine();
    s_parity();
    s_line_faults();
    summarize();
  end
endmodule // sci_receive_status_flags_bench
